// ==== status_msg_builder.sv ====
/*
 * Builds the device-specific status message of a fieldbus slave and
 * serves it byte by byte to the fetching master; registers over Wishbone.
 * Assumes synchronous inputs, one clock, asynchronous active-low reset.
 */
// Chosen here: the register offsets and the Wishbone register port.
//
// Overview of operation
// - Four-byte header: length, selector, zero slot, qualifier
// - Selector 0x81 narrow, 0xA1 wide layout
// - Checksum flag bit 0, cleared only by power cycle
// - Flag bits 4-7: unknown type and overflows
// - Internal-bus indication, code, argument in bytes 11-13
// - Start-up error code and argument in bytes 14-15
// - Fault entries only while module diagnosis enabled
// - Narrow entry: channel and module, full status
// - Entries paired consecutively from byte 16 to 61
// - Wide entry: module byte, channel plus status bits
// - Fault is status bit 6, bit 3 for serial
// - Extended diagnostics flag held set whenever out of reset
// - Content change signalled until master fetches it
module status_msg_builder
   import status_msg_pkg::*;
#(
   parameter int ENTRIES = MAX_ENTRIES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Module fault reports
   input wire logic fault_valid,
   input wire logic [7:0] fault_module,
   input wire logic [1:0] fault_channel,
   input wire logic [7:0] fault_status,
   input wire logic fault_serial,
   // Stored-settings checksum failure event
   input wire logic checksum_error,
   // Master fetch port
   input wire logic msg_rd,
   input wire logic [5:0] msg_addr,
   input wire logic fetch_done,
   output logic [7:0] msg_data,
   output logic msg_valid,
   // Indications
   output logic diag_change,
   output logic extended_diag_flag,
   output logic irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic diag_en;
   logic wide;
   logic checksum_flag;
   logic [3:0] vendor_flags;
   logic [23:0] ibus_word;
   logic [15:0] startup_word;
   logic [IRQ_BITS-1:0] irq_status;
   logic [IRQ_BITS-1:0] irq_mask;
   logic [4:0] entry_count;
   logic rd_stage;
   logic [5:0] rd_addr_q;
   logic rd_entry_q;
   logic [7:0] rd_header_q;
   logic [15:0] entry_rd_data;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire bus_req = wb_cyc_i && wb_stb_i;
   wire bus_first = bus_req && !wb_ack_o;
   wire bus_write = bus_req && wb_ack_o && wb_we_i;
   wire hit_control = wb_adr_i == REG_CONTROL;
   wire hit_flags = wb_adr_i == REG_FLAGS;
   wire hit_ibus = wb_adr_i == REG_IBUS;
   wire hit_startup = wb_adr_i == REG_STARTUP;
   wire hit_status = wb_adr_i == REG_IRQ_STATUS;
   wire hit_mask = wb_adr_i == REG_IRQ_MASK;
   wire hit_info = wb_adr_i == REG_INFO;
   wire wr_control = bus_write && hit_control && wb_sel_i[0];
   wire wr_flags = bus_write && hit_flags && wb_sel_i[0];
   wire wr_ibus = bus_write && hit_ibus;
   wire wr_startup = bus_write && hit_startup;
   wire wr_mask = bus_write && hit_mask && wb_sel_i[0];
   // Clear on the first cycle, same edge that captures the read data
   wire rd_status = bus_first && !wb_we_i && hit_status;
   wire clear_entries = wr_control && wb_dat_i[CTRL_CLEAR];
   // Disabling diagnosis empties the list just like an explicit clear
   wire list_reset = clear_entries || (wr_control && !wb_dat_i[CTRL_DIAG_EN]);

   // ----------------------------------------------------------------
   // Message fields
   // ----------------------------------------------------------------
   wire [7:0] flags_byte = {vendor_flags, 3'h0, checksum_flag};
   wire [7:0] length_byte = LENGTH_BASE + {2'h0, entry_count, 1'b0};
   wire [7:0] format_byte = wide ? FORMAT_WIDE : FORMAT_NARROW;

   // ----------------------------------------------------------------
   // Fault capture
   // ----------------------------------------------------------------
   wire fault_bit = fault_serial ? fault_status[STATUS_FAULT_SERIAL]
                                 : fault_status[STATUS_FAULT];
   wire fault_take = fault_valid && diag_en && fault_bit;
   wire list_full = int'(entry_count) >= ENTRIES;
   wire entry_add = fault_take && !list_full && !list_reset;
   wire entry_drop = fault_take && list_full;
   wire [7:0] narrow_first = {fault_channel, fault_module[5:0]};
   wire [7:0] wide_second = {fault_channel, fault_status[5:0]};
   wire [15:0] entry_word = wide ? {fault_module, wide_second}
                                 : {narrow_first, fault_status};

   wire content_change = entry_add || list_reset || wr_flags || wr_ibus
                         || wr_startup || (wr_control && wb_dat_i[CTRL_WIDE] != wide)
                         || (checksum_error && !checksum_flag);

   // ----------------------------------------------------------------
   // Fetch read path
   // ----------------------------------------------------------------
   wire [5:0] rel_addr = msg_addr - BYTE_FIRST_ENTRY;
   wire [4:0] rel_index = rel_addr[5:1];
   wire in_entries = (msg_addr >= BYTE_FIRST_ENTRY) && (msg_addr <= BYTE_LAST_ENTRY)
                     && (rel_index < entry_count);
   wire [7:0] entry_byte = rd_addr_q[0] ? entry_rd_data[7:0] : entry_rd_data[15:8];
   logic [7:0] header_byte;

   always_comb begin
      case (msg_addr)
         BYTE_LENGTH: header_byte = length_byte;
         BYTE_FORMAT: header_byte = format_byte;
         BYTE_SLOT: header_byte = 8'h00;
         BYTE_QUALIFIER: header_byte = 8'h00;
         BYTE_FLAGS: header_byte = flags_byte;
         BYTE_IBUS_IND: header_byte = ibus_word[7:0];
         BYTE_IBUS_CODE: header_byte = ibus_word[15:8];
         BYTE_IBUS_ARG: header_byte = ibus_word[23:16];
         BYTE_START_CODE: header_byte = startup_word[7:0];
         BYTE_START_ARG: header_byte = startup_word[15:8];
         default: header_byte = 8'h00;
      endcase
   end

   entry_store #(
      .WIDTH(16),
      .DEPTH(ENTRIES),
      .AW(5)
   ) u_store (
      .clock(clock),
      .wr_en(entry_add),
      .wr_addr(entry_count),
      .wr_data(entry_word),
      .rd_en(msg_rd),
      .rd_addr(rel_index),
      .rd_data(entry_rd_data)
   );

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   logic [31:0] read_word;

   always_comb begin
      read_word = RESET_WORD;
      if (hit_control) read_word = {30'h0, wide, diag_en};
      if (hit_flags) read_word = {24'h0, flags_byte};
      if (hit_ibus) read_word = {8'h00, ibus_word};
      if (hit_startup) read_word = {16'h0000, startup_word};
      if (hit_status) read_word = {29'h0, irq_status};
      if (hit_mask) read_word = {29'h0, irq_mask};
      if (hit_info) read_word = {15'h0, diag_change, 3'h0, entry_count, length_byte};
   end

   // ----------------------------------------------------------------
   // Wishbone handshake
   // ----------------------------------------------------------------
   // One wait state; unmapped addresses still ack and read zero
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= RESET_WORD;
      end else begin
         wb_ack_o <= bus_first;
         if (bus_first) wb_dat_o <= read_word;
      end
   end

   // ----------------------------------------------------------------
   // Byte lane merge
   // ----------------------------------------------------------------
   // Partial writes keep the untouched lanes of the error words
   wire [23:0] next_ibus_word;
   wire [15:0] next_startup_word;

   for (genvar lane = 0; lane < 3; lane++) begin : g_ibus_lane
      assign next_ibus_word[8*lane +: 8] = (wr_ibus && wb_sel_i[lane])
                                           ? wb_dat_i[8*lane +: 8]
                                           : ibus_word[8*lane +: 8];
   end

   for (genvar lane = 0; lane < 2; lane++) begin : g_startup_lane
      assign next_startup_word[8*lane +: 8] = (wr_startup && wb_sel_i[lane])
                                              ? wb_dat_i[8*lane +: 8]
                                              : startup_word[8*lane +: 8];
   end

   // ----------------------------------------------------------------
   // Control and content registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         diag_en <= 1'b0;
         wide <= 1'b0;
         vendor_flags <= 4'h0;
         ibus_word <= 24'h000000;
         startup_word <= 16'h0000;
         irq_mask <= RESET_MASK;
      end else begin
         if (wr_control) begin
            diag_en <= wb_dat_i[CTRL_DIAG_EN];
            wide <= wb_dat_i[CTRL_WIDE];
         end
         if (wr_flags) vendor_flags <= wb_dat_i[FLAG_OUT_OVF:FLAG_UNKNOWN];
         ibus_word <= next_ibus_word;
         startup_word <= next_startup_word;
         if (wr_mask) irq_mask <= wb_dat_i[IRQ_BITS-1:0];
      end
   end

   // Software can set but never clear it; only a power cycle does
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         checksum_flag <= 1'b0;
      end else if (checksum_error || (wr_flags && wb_dat_i[FLAG_CHECKSUM])) begin
         checksum_flag <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Entry list
   // ----------------------------------------------------------------
   // Layout is fixed per entry at capture; clear the list after a switch
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         entry_count <= 5'h00;
      end else if (list_reset) begin
         entry_count <= 5'h00;
      end else if (entry_add) begin
         entry_count <= entry_count + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // Fetch port
   // ----------------------------------------------------------------
   // Two cycles: memory read register, then the output register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_stage <= 1'b0;
         rd_addr_q <= 6'h00;
         rd_entry_q <= 1'b0;
         rd_header_q <= 8'h00;
         msg_valid <= 1'b0;
         msg_data <= 8'h00;
      end else begin
         rd_stage <= msg_rd;
         if (msg_rd) begin
            rd_addr_q <= msg_addr;
            rd_entry_q <= in_entries;
            rd_header_q <= header_byte;
         end
         msg_valid <= rd_stage;
         if (rd_stage) msg_data <= rd_entry_q ? entry_byte : rd_header_q;
      end
   end

   // ----------------------------------------------------------------
   // Change indication and interrupts
   // ----------------------------------------------------------------
   wire [IRQ_BITS-1:0] irq_events = {content_change, entry_drop, entry_add};

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         diag_change <= 1'b0;
         extended_diag_flag <= 1'b0;
         irq_status <= RESET_MASK;
         irq <= 1'b0;
      end else begin
         // New change wins over the master's fetch acknowledge
         diag_change <= content_change || (diag_change && !fetch_done);
         extended_diag_flag <= 1'b1;
         irq_status <= irq_events | (rd_status ? RESET_MASK : irq_status);
         irq <= |(irq_status & irq_mask);
      end
   end

endmodule

// ==== status_msg_pkg.sv ====
/*
 * Constants shared by the status message builder, its checker and the bench.
 * Assumes a single 100 MHz clock and a classic Wishbone register bus.
 */
package status_msg_pkg;

   // ----------------------------------------------------------------
   // Message layout (byte numbers within the diagnostic record)
   // ----------------------------------------------------------------
   localparam logic [5:0] BYTE_LENGTH = 6'h06;
   localparam logic [5:0] BYTE_FORMAT = 6'h07;
   localparam logic [5:0] BYTE_SLOT = 6'h08;
   localparam logic [5:0] BYTE_QUALIFIER = 6'h09;
   localparam logic [5:0] BYTE_FLAGS = 6'h0A;
   localparam logic [5:0] BYTE_IBUS_IND = 6'h0B;
   localparam logic [5:0] BYTE_IBUS_CODE = 6'h0C;
   localparam logic [5:0] BYTE_IBUS_ARG = 6'h0D;
   localparam logic [5:0] BYTE_START_CODE = 6'h0E;
   localparam logic [5:0] BYTE_START_ARG = 6'h0F;
   localparam logic [5:0] BYTE_FIRST_ENTRY = 6'h10;
   localparam logic [5:0] BYTE_LAST_ENTRY = 6'h3D;
   localparam logic [7:0] LENGTH_BASE = 8'h0A;
   localparam int MAX_ENTRIES = 23;
   localparam logic [7:0] FORMAT_NARROW = 8'h81;
   localparam logic [7:0] FORMAT_WIDE = 8'hA1;

   // ----------------------------------------------------------------
   // Vendor flag byte and channel status bits
   // ----------------------------------------------------------------
   localparam int FLAG_CHECKSUM = 0;
   localparam int FLAG_UNKNOWN = 4;
   localparam int FLAG_CFG_OVF = 5;
   localparam int FLAG_IN_OVF = 6;
   localparam int FLAG_OUT_OVF = 7;
   localparam int STATUS_FAULT = 6;
   localparam int STATUS_FAULT_SERIAL = 3;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CONTROL = 8'h00;
   localparam logic [7:0] REG_FLAGS = 8'h04;
   localparam logic [7:0] REG_IBUS = 8'h08;
   localparam logic [7:0] REG_STARTUP = 8'h0C;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK = 8'h14;
   localparam logic [7:0] REG_INFO = 8'h18;

   localparam int CTRL_DIAG_EN = 0;
   localparam int CTRL_WIDE = 1;
   localparam int CTRL_CLEAR = 2;

   localparam int IRQ_ADDED = 0;
   localparam int IRQ_DROPPED = 1;
   localparam int IRQ_CHANGED = 2;
   localparam int IRQ_BITS = 3;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [IRQ_BITS-1:0] RESET_MASK = 3'h0;

endpackage

// ==== entry_store.sv ====
/*
 * Small synchronous memory for fault entries: one write port, one read
 * port with registered read data. Assumes one clock domain.
 */
module entry_store #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 23,
   parameter int AW = 5
) (
   // Clock
   input wire logic clock,
   // Write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // No reset: contents are only read below the live entry count
   always_ff @(posedge clock) begin
      if (wr_en && (int'(wr_addr) < DEPTH)) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en && (int'(rd_addr) < DEPTH)) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// ==== status_msg_builder_checker.sv ====
/*
 * Concurrent checks on the status message builder's ports.
 * Assumes one clock, reset rstn active low, bound to every instance.
 */
module status_msg_builder_checker
   import status_msg_pkg::*;
#(
   parameter int ENTRIES = MAX_ENTRIES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Bus and fault reports
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic fault_valid,
   input wire logic [7:0] fault_status,
   input wire logic fault_serial,
   input wire logic checksum_error,
   // Fetch port and indications
   input wire logic msg_rd,
   input wire logic [5:0] msg_addr,
   input wire logic fetch_done,
   input wire logic [7:0] msg_data,
   input wire logic msg_valid,
   input wire logic diag_change,
   input wire logic extended_diag_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_ack_once;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
   property p_ext_flag;
      $past(rstn) |-> extended_diag_flag;
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("ext flag low");
   property p_change_holds;
      diag_change && !fetch_done |=> diag_change;
   endproperty
   a_change_holds: assert property (p_change_holds) else $error("change lost");
   property p_change_drop;
      $fell(diag_change) |-> $past(fetch_done);
   endproperty
   a_change_drop: assert property (p_change_drop) else $error("change dropped");
   property p_fetch_lat;
      msg_rd |-> ##2 msg_valid;
   endproperty
   a_fetch_lat: assert property (p_fetch_lat) else $error("no fetch answer");
   property p_fetch_only;
      msg_valid |-> $past(msg_rd, 2);
   endproperty
   a_fetch_only: assert property (p_fetch_only) else $error("stray answer");
   property p_zero_hdr;
      msg_rd && (msg_addr == BYTE_SLOT || msg_addr == BYTE_QUALIFIER) |-> ##2 msg_data == 8'h00;
   endproperty
   a_zero_hdr: assert property (p_zero_hdr) else $error("slot not zero");
   property p_beyond;
      msg_rd && msg_addr > BYTE_LAST_ENTRY |-> ##2 msg_data == 8'h00;
   endproperty
   a_beyond: assert property (p_beyond) else $error("byte past end");
   property p_length;
      msg_rd && msg_addr == BYTE_LENGTH |-> ##2 !msg_data[0] && msg_data >= LENGTH_BASE
         && msg_data <= LENGTH_BASE + 8'(2 * ENTRIES);
   endproperty
   a_length: assert property (p_length) else $error("bad length");
   property p_not_faulty;
      fault_valid && !(fault_serial ? fault_status[STATUS_FAULT_SERIAL] : fault_status[STATUS_FAULT])
         && !diag_change && !wb_cyc_i && !checksum_error |=> !diag_change;
   endproperty
   a_not_faulty: assert property (p_not_faulty) else $error("healthy entry");

   c_fetched: cover property (diag_change && fetch_done);
   c_fault: cover property (fault_valid && diag_change);
   c_entry: cover property (msg_rd && msg_addr == BYTE_LAST_ENTRY);
endmodule

bind status_msg_builder status_msg_builder_checker #(.ENTRIES(ENTRIES)) u_chk (
   .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .fault_valid(fault_valid), .fault_status(fault_status),
   .fault_serial(fault_serial), .checksum_error(checksum_error), .msg_rd(msg_rd),
   .msg_addr(msg_addr), .fetch_done(fetch_done), .msg_data(msg_data),
   .msg_valid(msg_valid), .diag_change(diag_change),
   .extended_diag_flag(extended_diag_flag));

// ==== fetch_master.sv ====
/*
 * Behavioural fieldbus master that fetches record bytes on request.
 * Assumes the builder answers a fetch two cycles after taking it.
 */
module fetch_master (
   // Clock
   input wire logic clock,
   // Fetch port
   output logic msg_rd,
   output logic [5:0] msg_addr,
   output logic fetch_done,
   input wire logic [7:0] msg_data,
   input wire logic msg_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      msg_rd = 1'b0;
      msg_addr = 6'h00;
      fetch_done = 1'b0;
   end
   // Idle address is inverted so a stale value never looks valid
   task automatic fetch(input logic [5:0] a, output logic [7:0] d);
      d = 'x;
      @(posedge clock);
      msg_rd <= 1'b1;
      msg_addr <= a;
      @(posedge clock);
      msg_rd <= 1'b0;
      msg_addr <= ~a;
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         if (msg_valid === 1'b1) begin
            d = msg_data;
            break;
         end
      end
   endtask
   task automatic done();
      @(posedge clock);
      fetch_done <= 1'b1;
      @(posedge clock);
      fetch_done <= 1'b0;
   endtask
endmodule

// ==== tb_top.sv ====
/*
 * Self-checking bench for the status message builder.
 * Assumes the partner fetch master and the bound checker.
 */
module tb_top;
   import status_msg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rstn, cyc, stb, we, ack, f_v, f_ser, cks, rd, done, valid, chg, ext, irq;
   logic [7:0] adr, f_mod, f_st, m_data;
   logic [3:0] sel;
   logic [31:0] dat_i, dat_o, r;
   logic [1:0] f_ch;
   logic [5:0] m_addr;
   int num_errors = 0, total_checks = 0, cycles = 0;

   status_msg_builder u_status_msg_builder (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .fault_valid(f_v), .fault_module(f_mod),
      .fault_channel(f_ch), .fault_status(f_st), .fault_serial(f_ser),
      .checksum_error(cks), .msg_rd(rd), .msg_addr(m_addr), .fetch_done(done),
      .msg_data(m_data), .msg_valid(valid), .diag_change(chg),
      .extended_diag_flag(ext), .irq(irq));
   fetch_master u_fetch_master (.clock(clock), .msg_rd(rd), .msg_addr(m_addr),
      .fetch_done(done), .msg_data(m_data), .msg_valid(valid));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (num_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Single classic cycle; the wait is cut short only by the timeout
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge clock);
      {cyc, stb, we, adr, dat_i, sel} <= {2'b11, w, a, d, s};
      do @(posedge clock); while (ack !== 1'b1);
      r = dat_o;
      {cyc, stb, we} <= 3'h0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hF);
      check(r, e);
   endtask
   task automatic fc(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_fetch_master.fetch(a, d);
      check({24'h0, d}, {24'h0, e});
   endtask
   task automatic fault(input logic [7:0] m, input logic [1:0] c, input logic [7:0] s,
      input logic ser);
      @(posedge clock);
      {f_v, f_mod, f_ch, f_st, f_ser} <= {1'b1, m, c, s, ser};
      @(posedge clock);
      f_v <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Clock, reset and timeout
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         num_errors++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] ib [0:4] = '{8'h44, 8'h22, 8'h33, 8'h66, 8'h55};
      {rstn, cyc, stb, we, f_v, f_ser, cks} = 7'h0;
      {adr, f_mod, f_st, f_ch, sel, dat_i} = '0;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      cks <= 1'b1;
      @(posedge clock);
      cks <= 1'b0;
      check({31'h0, ext}, 32'h1);
      fc(BYTE_LENGTH, 8'h0A);
      fc(BYTE_FORMAT, FORMAT_NARROW);
      fc(BYTE_SLOT, 8'h00);
      fc(BYTE_QUALIFIER, 8'h00);
      fc(BYTE_FLAGS, 8'h01);
      bus(1'b1, REG_FLAGS, 32'hF0, 4'hF);
      fc(BYTE_FLAGS, 8'hF1);
      bus(1'b1, REG_FLAGS, 32'h00, 4'hF);
      fc(BYTE_FLAGS, 8'h01);
      bus(1'b1, REG_IBUS, 32'h0033_2211, 4'hF);
      bus(1'b1, REG_IBUS, 32'hFFFF_FF44, 4'h1);
      bus(1'b1, REG_STARTUP, 32'h5566, 4'hF);
      for (int i = 0; i < 5; i++) fc(BYTE_IBUS_IND + 6'(i), ib[i]);
      fault(8'h05, 2'h2, 8'h40, 1'b0);
      fc(BYTE_LENGTH, 8'h0A);
      bus(1'b1, REG_CONTROL, 32'h1, 4'hF);
      bus(1'b1, REG_IRQ_MASK, 32'h7, 4'hF);
      bus(1'b0, REG_IRQ_STATUS, 32'h0, 4'hF);
      fault(8'h05, 2'h2, 8'h40, 1'b0);
      fault(8'h3F, 2'h3, 8'h08, 1'b1);
      fc(BYTE_FIRST_ENTRY, 8'h85);
      fc(6'h11, 8'h40);
      fc(6'h12, 8'hFF);
      fc(6'h13, 8'h08);
      fc(BYTE_LENGTH, 8'h0E);
      check({31'h0, chg}, 32'h1);
      u_fetch_master.done();
      @(posedge clock);
      check({31'h0, chg}, 32'h0);
      fault(8'h07, 2'h0, 8'h08, 1'b0);
      fc(BYTE_LENGTH, 8'h0E);
      check({31'h0, irq}, 32'h1);
      rd_chk(REG_IRQ_STATUS, 32'h5);
      rd_chk(REG_IRQ_STATUS, 32'h0);
      repeat (2) @(posedge clock);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, REG_CONTROL, 32'h7, 4'hF);
      bus(1'b1, REG_IRQ_MASK, 32'h2, 4'hF);
      fault(8'hC8, 2'h1, 8'hC5, 1'b0);
      fc(BYTE_FORMAT, FORMAT_WIDE);
      fc(BYTE_FIRST_ENTRY, 8'hC8);
      fc(6'h11, 8'h45);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, REG_CONTROL, 32'h7, 4'hF);
      rd_chk(REG_IRQ_STATUS, 32'h5);
      for (int i = 0; i < 24; i++) begin
         @(posedge clock);
         {f_v, f_mod, f_ch, f_st, f_ser} <= {1'b1, 8'(i + 1), 2'h0, 8'h41, 1'b0};
      end
      @(posedge clock);
      f_v <= 1'b0;
      fc(BYTE_LAST_ENTRY - 6'h1, 8'h17);
      fc(BYTE_LAST_ENTRY, 8'h01);
      fc(BYTE_LENGTH, 8'h38);
      fc(6'h3E, 8'h00);
      check({31'h0, irq}, 32'h1);
      rd_chk(REG_IRQ_STATUS, 32'h7);
      rd_chk(REG_INFO, 32'h0001_1738);
      rd_chk(8'h1C, 32'h0);
      stop_test();
   end
endmodule
